//--- lmpmc_pkg.sv
// Shared constants and bus carrier for the LED matrix power mode control
package lmpmc_pkg;

    localparam int          ADDR_W        = 9;
    localparam int          DATA_W        = 8;
    localparam int          PWM_W         = 8;
    localparam int          PULL_W        = 3;

    // Address bit that selects the function page over the PWM page
    localparam int          FUNC_PAGE_BIT = 8;

    localparam logic [7:0]  CFG_OFFS      = 8'h00;
    localparam logic [7:0]  PULL_OFFS     = 8'h02;

    localparam int          SOFT_BIT      = 0;
    localparam int          SWITCH_LSB    = 4;
    localparam int          SINK_LSB      = 0;
    localparam logic [7:0]  PULL_MASK     = 8'h77;

    localparam logic        SOFT_RST      = 1'h0;
    localparam logic [2:0]  PULL_CODE_RST = 3'h5;
    localparam logic [7:0]  PULL_RST      = 8'h55;
    localparam logic [7:0]  PWM_RST       = 8'h00;
    localparam logic [2:0]  PULL_NONE     = 3'h0;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } lmpmc_bus_req_t;

endpackage

//--- lmpmc_pin_sync.sv
// Two-stage synchroniser and rising-edge detector for the shutdown pin
`timescale 1ns/1ps

module lmpmc_pin_sync (
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Reset low: the pin counts as in shutdown until sampled
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= 1'h0;
            sync_r <= 1'h0;
            prev_r <= 1'h0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise  = sync_r & ~prev_r;

    a_rise_single: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_rise |=> !o_rise)
        else $error("shutdown pin edge pulse longer than one cycle");

endmodule

//--- lmpmc_top.sv
// LED matrix PWM dimming, de-ghost pulls and shutdown control
`timescale 1ns/1ps

// Summary of operation
// - Only PWM dimming, 256 steps per LED
// - PWM value equals duty step count directly
// - New PWM values act without commit
// - Pulls connect only while output is off
// - Pull strengths selectable at function offset 02h
// - Shutdown keeps every register value
// - Soft shutdown bit zero blanks all sources
// - Registers stay accessible in soft shutdown
// - Pin low disables all analog circuits
// - Pin high resumes normal operation
// - Pin rise resets serial interface only
// - Function registers accessible while pin low
// - Soft shutdown bit one enables sources
// - Pull codes in D6:D4, D2:D0, default 101

module lmpmc_top #(
    parameter int NUM_SW = 6,
    parameter int NUM_CS = 30
) (
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst_b,
    input  wire lmpmc_pkg::lmpmc_bus_req_t i_bus,
    input  wire logic                    i_shutdown_pin_n,
    output logic [lmpmc_pkg::DATA_W-1:0] o_rdata,
    output logic [NUM_CS-1:0]            o_sink_on,
    output logic [NUM_SW-1:0]            o_switch_on,
    output logic [NUM_CS-1:0]            o_sink_pullup_en,
    output logic [NUM_SW-1:0]            o_switch_pulldown_en,
    output logic [lmpmc_pkg::PULL_W-1:0] o_sink_pull_code,
    output logic [lmpmc_pkg::PULL_W-1:0] o_switch_pull_code,
    output logic                         o_current_en,
    output logic                         o_analog_en,
    output logic                         o_serial_rst
);

    localparam int         NUM_LED  = NUM_SW * NUM_CS;
    localparam int         SW_IDX_W = (NUM_SW > 1) ? $clog2(NUM_SW) : 1;
    localparam logic [7:0] LED_LAST = 8'(NUM_LED - 1);
    localparam logic [SW_IDX_W-1:0] SW_LAST = SW_IDX_W'(NUM_SW - 1);
    localparam logic [lmpmc_pkg::PWM_W-1:0] CNT_LAST = 8'hFF;

    // Lit while the period counter is below the stored step count
    function automatic logic led_lit(input logic [7:0] value,
                                     input logic [7:0] cnt);
        led_lit = (cnt < value);
    endfunction

    // A pull engages only when the output is off and a resistor is chosen
    function automatic logic pull_on(input logic       analog,
                                     input logic       drive,
                                     input logic [2:0] code);
        pull_on = analog && !drive && (code != lmpmc_pkg::PULL_NONE);
    endfunction

    logic                         pin_high;
    logic                         pin_rise;

    logic [7:0]                   pwm_r [NUM_LED];
    logic                         soft_shutdown_n_r;
    logic [7:0]                   pull_r;
    logic [7:0]                   cnt_r;
    logic [SW_IDX_W-1:0]          sw_idx_r;

    logic [7:0]                   rdata_nxt;
    logic [NUM_CS-1:0]            sink_on_nxt;
    logic [NUM_SW-1:0]            switch_on_nxt;
    logic [NUM_CS-1:0]            sink_pull_nxt;
    logic [NUM_SW-1:0]            switch_pull_nxt;

    lmpmc_pin_sync u_pin_sync (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_pin   (i_shutdown_pin_n),
        .o_level (pin_high),
        .o_rise  (pin_rise)
    );

    // Address decode
    wire       func_sel = i_bus.addr[lmpmc_pkg::FUNC_PAGE_BIT];
    wire [7:0] offs     = i_bus.addr[7:0];
    wire       pwm_hit  = !func_sel && (offs <= LED_LAST);
    wire       cfg_hit  = func_sel && (offs == lmpmc_pkg::CFG_OFFS);
    wire       pull_hit = func_sel && (offs == lmpmc_pkg::PULL_OFFS);
    wire       pwm_we   = i_bus.wr && pwm_hit;
    wire       cfg_we   = i_bus.wr && cfg_hit;
    wire       pull_we  = i_bus.wr && pull_hit;

    wire [2:0] sink_code   = pull_r[lmpmc_pkg::SINK_LSB +: lmpmc_pkg::PULL_W];
    wire [2:0] switch_code = pull_r[lmpmc_pkg::SWITCH_LSB +:
                                    lmpmc_pkg::PULL_W];

    // Sources run only with the soft bit set and the pin released
    wire       active  = soft_shutdown_n_r && pin_high;
    wire       analog  = pin_high;
    wire       wrap    = (cnt_r == CNT_LAST);

    // Read data: unmapped offsets read zero, strobe-free cycles read zero
    wire [7:0] cfg_rd  = {7'h00, soft_shutdown_n_r};
    wire [7:0] sel_rd  = pwm_hit  ? pwm_r[offs] :
                         cfg_hit  ? cfg_rd :
                         pull_hit ? pull_r : 8'h00;
    assign rdata_nxt = i_bus.rd ? sel_rd : 8'h00;

    // Registers are written in every mode; shutdown never clears them
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            soft_shutdown_n_r <= lmpmc_pkg::SOFT_RST;
            pull_r            <= lmpmc_pkg::PULL_RST;
        end else begin
            if (cfg_we) begin
                soft_shutdown_n_r <= i_bus.wdata[lmpmc_pkg::SOFT_BIT];
            end
            if (pull_we) begin
                pull_r <= i_bus.wdata & lmpmc_pkg::PULL_MASK;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < NUM_LED; i++) begin
                pwm_r[i] <= lmpmc_pkg::PWM_RST;
            end
        end else if (pwm_we) begin
            pwm_r[offs] <= i_bus.wdata;
        end
    end

    // Period counter and switch scan keep running to stay phase-aligned
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r    <= 8'h00;
            sw_idx_r <= '0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            if (wrap) begin
                sw_idx_r <= (sw_idx_r == SW_LAST) ? '0 : sw_idx_r + 1'b1;
            end
        end
    end

    // Drive and pull decisions; the stored value is compared directly
    genvar gy;
    generate
        for (gy = 0; gy < NUM_CS; gy++) begin : g_sink
            wire [7:0] lvl = pwm_r[int'(sw_idx_r) * NUM_CS + gy];
            assign sink_on_nxt[gy]   = active && led_lit(lvl, cnt_r);
            assign sink_pull_nxt[gy] = pull_on(analog, sink_on_nxt[gy],
                                               sink_code);
        end
        for (gy = 0; gy < NUM_SW; gy++) begin : g_switch
            assign switch_on_nxt[gy]   = active &&
                                         (sw_idx_r == SW_IDX_W'(gy));
            assign switch_pull_nxt[gy] = pull_on(analog, switch_on_nxt[gy],
                                                 switch_code);
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata              <= 8'h00;
            o_sink_on            <= '0;
            o_switch_on          <= '0;
            o_sink_pullup_en     <= '0;
            o_switch_pulldown_en <= '0;
            o_sink_pull_code     <= lmpmc_pkg::PULL_CODE_RST;
            o_switch_pull_code   <= lmpmc_pkg::PULL_CODE_RST;
            o_current_en         <= 1'h0;
            o_analog_en          <= 1'h0;
            o_serial_rst         <= 1'h0;
        end else begin
            o_rdata              <= rdata_nxt;
            o_sink_on            <= sink_on_nxt;
            o_switch_on          <= switch_on_nxt;
            o_sink_pullup_en     <= sink_pull_nxt;
            o_switch_pulldown_en <= switch_pull_nxt;
            o_sink_pull_code     <= sink_code;
            o_switch_pull_code   <= switch_code;
            o_current_en         <= active;
            o_analog_en          <= analog;
            o_serial_rst         <= pin_rise;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_soft_blank: assert property (
        !soft_shutdown_n_r |=> (o_sink_on == '0) && (o_switch_on == '0)
                               && !o_current_en)
        else $error("matrix driven during soft shutdown");

    a_soft_enable: assert property (
        soft_shutdown_n_r && pin_high |=> o_current_en)
        else $error("sources off with soft bit set and pin high");

    a_hw_analog_off: assert property (
        !pin_high |=> !o_analog_en && (o_sink_on == '0)
                      && (o_sink_pullup_en == '0)
                      && (o_switch_pulldown_en == '0))
        else $error("analog active while shutdown pin low");

    a_pin_resume: assert property (
        $rose(pin_high) |=> o_analog_en ##0 o_serial_rst)
        else $error("no resume or serial reset after pin rise");

    a_pull_off_only: assert property (
        ((o_sink_pullup_en & o_sink_on) == '0) &&
        ((o_switch_pulldown_en & o_switch_on) == '0))
        else $error("pull resistor engaged on a driven output");

    a_pull_keep: assert property (
        !pull_we |=> $stable(pull_r))
        else $error("pull selection changed without a write");

    a_cfg_keep_rise: assert property (
        pin_rise && !cfg_we |=> $stable(soft_shutdown_n_r))
        else $error("soft shutdown bit lost on pin rise");

    a_cfg_read_back: assert property (
        i_bus.rd && cfg_hit |=> o_rdata == {7'h00, $past(soft_shutdown_n_r)})
        else $error("config read returned wrong data");

    a_pull_write: assert property (
        pull_we |=> ##1 o_sink_pull_code == $past(i_bus.wdata[2:0], 2))
        else $error("pull write not applied");

    a_pwm_now: assert property (
        pwm_we && (offs == 8'h00) |=> pwm_r[0] == $past(i_bus.wdata))
        else $error("pwm write not applied at once");

    a_pwm_step: assert property (
        active && (sw_idx_r == '0) && (cnt_r < pwm_r[0]) |=> o_sink_on[0])
        else $error("led dark below its step count");

    a_rdata_idle: assert property (
        !i_bus.rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");

    a_cfg_keep: assert property (
        !cfg_we |=> $stable(soft_shutdown_n_r))
        else $error("soft shutdown bit changed without a write");

    a_pwm_keep: assert property (
        !(pwm_we && (offs == 8'h00)) |=> $stable(pwm_r[0]))
        else $error("pwm value changed without a write");

    a_pwm_read_back: assert property (
        i_bus.rd && pwm_hit && (offs == 8'h00)
        |=> o_rdata == $past(pwm_r[0]))
        else $error("pwm read returned wrong data");

    a_pull_read_back: assert property (
        i_bus.rd && pull_hit |=> o_rdata == $past(pull_r))
        else $error("pull selection read returned wrong data");

    a_pull_sw_write: assert property (
        pull_we |=> ##1 o_switch_pull_code == $past(i_bus.wdata[6:4], 2))
        else $error("switch pull code not applied");

    a_pull_none: assert property (
        sink_code == lmpmc_pkg::PULL_NONE |=> o_sink_pullup_en == '0)
        else $error("sink pull-up engaged with no resistor chosen");

    a_pull_none_sw: assert property (
        switch_code == lmpmc_pkg::PULL_NONE |=> o_switch_pulldown_en == '0)
        else $error("switch pull-down engaged with no resistor chosen");

    a_analog_follow: assert property (
        pin_high |=> o_analog_en)
        else $error("analog off with shutdown pin high");

    a_serial_pulse: assert property (
        o_serial_rst |=> !o_serial_rst)
        else $error("serial interface reset longer than one cycle");

    a_serial_cause: assert property (
        !pin_rise |=> !o_serial_rst)
        else $error("serial interface reset without a pin rise");

    a_serial_rise: assert property (
        pin_rise |=> o_serial_rst)
        else $error("pin rise gave no serial interface reset");

    a_scan_onehot: assert property (
        active |=> $onehot(o_switch_on))
        else $error("not exactly one scan switch on while active");

    a_cnt_step: assert property (
        !wrap |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("period counter skipped a step");

    a_cnt_wrap: assert property (
        wrap |=> (cnt_r == 8'h00) && (sw_idx_r != $past(sw_idx_r)))
        else $error("period did not end after 256 steps");

    a_scan_hold: assert property (
        !wrap |=> $stable(sw_idx_r))
        else $error("scan switch moved inside a period");

    a_pwm_dark: assert property (
        active && (sw_idx_r == '0) && (cnt_r >= pwm_r[0]) |=> !o_sink_on[0])
        else $error("led lit beyond its step count");

    a_hw_blank: assert property (
        !pin_high |=> !o_current_en && (o_switch_on == '0))
        else $error("sources on while shutdown pin low");

    a_pwm_hw_write: assert property (
        pwm_we && !pin_high && (offs == 8'h00)
        |=> pwm_r[0] == $past(i_bus.wdata))
        else $error("pwm write lost during pin shutdown");

    a_cfg_write: assert property (
        cfg_we |=> soft_shutdown_n_r ==
                   $past(i_bus.wdata[lmpmc_pkg::SOFT_BIT]))
        else $error("soft shutdown bit write not applied");

    a_rdata_unmapped: assert property (
        i_bus.rd && !pwm_hit && !cfg_hit && !pull_hit
        |=> o_rdata == 8'h00)
        else $error("unmapped read returned data");

    a_sink_pull_soft: assert property (
        pin_high && !active && (sink_code != lmpmc_pkg::PULL_NONE)
        |=> o_sink_pullup_en == '1)
        else $error("sink pull-up missing on an off output");

    a_switch_pull_soft: assert property (
        pin_high && !active && (switch_code != lmpmc_pkg::PULL_NONE)
        |=> o_switch_pulldown_en == '1)
        else $error("switch pull-down missing on an off output");

    a_current_pin: assert property (
        $rose(pin_high) && soft_shutdown_n_r |=> o_current_en)
        else $error("sources stayed off after pin rise");

    c_pin_rise:   cover property (o_serial_rst);
    c_pull_write: cover property (pull_we);
    c_led_lit:    cover property (o_sink_on != '0);
    c_soft_off:   cover property ($fell(soft_shutdown_n_r));
    c_hw_off:     cover property ($fell(pin_high));

endmodule

//--- lmpmc_host.sv
// Host model driving the register port and the shutdown pin
`timescale 1ns/1ps

module lmpmc_host (
    input  wire logic                   i_mclk,
    input  wire logic [7:0]             i_rdata,
    output lmpmc_pkg::lmpmc_bus_req_t   o_bus,
    output logic                        o_shutdown_pin_n
);
    initial begin
        o_bus = '0;
        o_shutdown_pin_n = 1'h1;
    end

    // One-cycle write strobe, released on the edge that takes it
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge i_mclk);
        o_bus.wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge i_mclk);
        o_bus.rd <= 1'h0;
        #1;
        d = i_rdata;
    endtask

    task automatic pin(input logic v);
        @(posedge i_mclk);
        o_shutdown_pin_n <= v;
    endtask
endmodule

//--- testbench.sv
// Self-checking bench for the LED matrix power mode control
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end

module testbench;
    logic                       i_mclk = 1'h0;
    logic                       i_rst_b = 1'h0;
    lmpmc_pkg::lmpmc_bus_req_t  bus;
    logic                       pin_n;
    logic [7:0]                 rdata;
    logic [29:0]                sink_on;
    logic [29:0]                sink_pu;
    logic [5:0]                 sw_on;
    logic [5:0]                 sw_pd;
    logic [2:0]                 sink_code;
    logic [2:0]                 sw_code;
    logic                       cur_en;
    logic                       ana_en;
    logic                       ser_rst;
    int                         bad_count = 0;
    int                         checks = 0;
    logic [31:0]                seed = 32'h0000_0440;
    logic [7:0]                 pwm [6];
    logic [7:0]                 d;
    int                         sum;
    int                         n;

    always #2.5 i_mclk = ~i_mclk;

    lmpmc_host u_host (.i_mclk(i_mclk), .i_rdata(rdata), .o_bus(bus),
        .o_shutdown_pin_n(pin_n));

    lmpmc_top u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(bus),
        .i_shutdown_pin_n(pin_n), .o_rdata(rdata), .o_sink_on(sink_on),
        .o_switch_on(sw_on), .o_sink_pullup_en(sink_pu),
        .o_switch_pulldown_en(sw_pd), .o_sink_pull_code(sink_code),
        .o_switch_pull_code(sw_code), .o_current_en(cur_en),
        .o_analog_en(ana_en), .o_serial_rst(ser_rst));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Lit cycles of sink 0 over one full scan round
    function automatic int exp_sum();
        int t;
        t = 0;
        foreach (pwm[i]) t += pwm[i];
        return t;
    endfunction

    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask

    task automatic stop_test();
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'h1;
        u_host.rd(9'h100, d);
        `CHK(d, 8'h00)
        `CHK(cur_en, 1'h0)
        u_host.rd(9'h102, d);
        `CHK(d, 8'h55)
        `CHK(sw_code, 3'h5)
        u_host.rd(9'h1FF, d);
        `CHK(d, 8'h00)
        u_host.wr(9'h102, 8'hFF);
        u_host.rd(9'h102, d);
        `CHK(d, 8'h77)
        `CHK(sink_code, 3'h7)
        `CHK(sw_code, 3'h7)
        foreach (pwm[i]) begin
            seed = xs(seed);
            pwm[i] = seed[7:0];
        end
        pwm[0] = 8'h04;
        pwm[1] = 8'hFF;
        pwm[2] = 8'h00;
        foreach (pwm[i]) begin
            u_host.wr(9'(i * 30), pwm[i]);
            u_host.rd(9'(i * 30), d);
            `CHK(d, pwm[i])
        end
        `CHK(sink_on, 30'h0)
        u_host.wr(9'h100, 8'h01);
        repeat (4) tick();
        `CHK(cur_en, 1'h1)
        sum = 0;
        repeat (1536) begin
            tick();
            sum += int'(sink_on[0]);
            `CHK(sink_pu[0], ~sink_on[0])
            `CHK(sw_pd[0], ~sw_on[0])
        end
        `CHK(sum, exp_sum())
        `CHK($countones(sw_on), 1)
        u_host.wr(9'h100, 8'h00);
        repeat (4) tick();
        `CHK(cur_en, 1'h0)
        `CHK(sink_on, 30'h0)
        `CHK(sink_pu, 30'h3FFF_FFFF)
        `CHK(sw_pd, 6'h3F)
        u_host.wr(9'h102, 8'h00);
        repeat (2) tick();
        `CHK(sink_pu, 30'h0)
        `CHK(sw_pd, 6'h00)
        u_host.wr(9'h102, 8'h55);
        u_host.wr(9'h100, 8'h01);
        u_host.pin(1'h0);
        repeat (5) tick();
        `CHK(ana_en, 1'h0)
        `CHK(sink_pu, 30'h0)
        u_host.wr(9'h000, 8'h3C);
        u_host.rd(9'h000, d);
        `CHK(d, 8'h3C)
        u_host.wr(9'h100, 8'h00);
        u_host.rd(9'h100, d);
        `CHK(d, 8'h00)
        // Function page rewritten before the pin rises again
        u_host.wr(9'h102, 8'h77);
        u_host.wr(9'h100, 8'h01);
        u_host.pin(1'h1);
        n = 0;
        while (ser_rst !== 1'h1 && n < 8) begin
            tick();
            n++;
        end
        `CHK(n, 3)
        tick();
        `CHK(ser_rst, 1'h0)
        tick();
        `CHK(ana_en, 1'h1)
        `CHK(cur_en, 1'h1)
        u_host.rd(9'h000, d);
        `CHK(d, 8'h3C)
        u_host.rd(9'h1E, d);
        `CHK(d, pwm[1])
        u_host.rd(9'h102, d);
        `CHK(d, 8'h77)
        u_host.rd(9'h100, d);
        `CHK(d, 8'h01)
        stop_test();
    end
endmodule
